// file: src/mct_machine_cycle_timing.sv
/*
  Machine-cycle timing and pin control of a single-chip microcomputer:
  phase enable, write clock, ready pulse, reset and event-input
  conditioning, timer reference strobes and the four I/O ports.
  Assumes clock_i is the time base and that the instruction decoder
  presents its port requests and cycle length on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none

`include "mct_defs.svh"

// Operation
// - Phase enable is time base divided by two
// - Write clock each four or six phases
// - Ready pulse idles high, low 8-12 phases
// - Ready falls three phases after valid data
// - Reset holds core; restart at zero
// - Event input polarity selectable; irq and timer
// - Timer load/start/stop at write instruction end
// - Timer read captured at read instruction end
// - Interrupt timing from request cycle start
// - Free-running intervals do not accumulate error
// - Tick period is phase times prescale; prescale zero gives one phase
// - Each port line is input or latch
module mct_machine_cycle_timing
  import mct_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned ADDR_W = 11
)
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic reset_pin_n_i,
  input wire logic external_event_input_i,
  input wire logic event_active_high_i,
  input wire logic long_cycle_i,
  input wire logic last_cycle_i,
  input wire logic privileged_i,
  input wire logic io_write_i,
  input wire logic io_read_i,
  input wire logic [`MCT_PORT_W-1:0] io_port_i,
  input wire logic [WIDTH-1:0] io_wdata_i,
  input wire logic [WIDTH-1:0] prescale_i,
  input wire logic irq_ack_i,
  input wire logic [4*WIDTH-1:0] port_pin_i,
  output logic [4*WIDTH-1:0] port_pin_o,
  output logic [4*WIDTH-1:0] port_pin_oe_o,
  output logic [WIDTH-1:0] io_rdata_o,
  output logic phase_en_o,
  output logic write_clk_o,
  output logic cycle_start_o,
  output logic ready_strobe_n_o,
  output logic core_reset_o,
  output logic [ADDR_W-1:0] reset_vector_o,
  output logic timer_write_o,
  output logic [WIDTH-1:0] timer_wdata_o,
  output logic timer_capture_o,
  output logic icp_write_o,
  output logic event_level_o,
  output logic event_count_o,
  output logic irq_request_o,
  output logic irq_take_o,
  output logic timer_tick_o
);

  // =====================================================================
  // Derived counts: ready pulse in time-base cycles, cycle lengths in phases
  localparam int unsigned STB_DELAY_CYC = `MCT_STB_DELAY_PH * `MCT_TB_PER_PHASE;
  localparam int unsigned STB_LOW_CYC = `MCT_STB_LOW_PH * `MCT_TB_PER_PHASE;
  localparam int unsigned SCW = 5;
  localparam logic [SCW-1:0] STB_DELAY_LAST = SCW'(STB_DELAY_CYC - 1);
  localparam logic [SCW-1:0] STB_LOW_LAST = SCW'(STB_LOW_CYC - 1);
  localparam logic [2:0] SHORT_LAST = 3'(`MCT_SHORT_PHASES - 1);
  localparam logic [2:0] LONG_LAST = 3'(`MCT_LONG_PHASES - 1);

  // =====================================================================
  // Phase enable
  logic phase_div;

  // Divide the time base by two
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      phase_div <= 1'b0;
    else
      phase_div <= !phase_div;
  end

  assign phase_en_o = phase_div;

  // =====================================================================
  // Pin synchronisers for reset and event inputs
  logic rst_meta;
  logic rst_sync;
  logic evt_meta;
  logic evt_sync;

  // Two flops before any logic looks at the pins
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
      evt_meta <= 1'b0;
      evt_sync <= 1'b0;
    end
    else
    begin
      rst_meta <= reset_pin_n_i;
      rst_sync <= rst_meta;
      evt_meta <= external_event_input_i;
      evt_sync <= evt_meta;
    end
  end

  // =====================================================================
  // Core reset and start address
  // Reset applies on the phase edge so a brief glitch is not half-taken
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      core_reset_o <= 1'b1;
    else if (phase_en_o)
      core_reset_o <= !rst_sync;
  end

  assign reset_vector_o = ADDR_W'(`MCT_RESET_VECTOR);

  // =====================================================================
  // Machine cycle sequencer
  logic [2:0] phase_cnt;
  logic long_q;
  logic cycle_end;
  logic [2:0] cycle_last;

  assign cycle_last = long_q ? LONG_LAST : SHORT_LAST;
  assign cycle_end = phase_en_o && (phase_cnt == cycle_last) && !core_reset_o;

  // Count phases; sample the cycle length at each cycle start
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      phase_cnt <= 3'h0;
      long_q <= 1'b0;
      cycle_start_o <= 1'b0;
    end
    else if (core_reset_o)
    begin
      phase_cnt <= 3'h0;
      long_q <= long_cycle_i;
      cycle_start_o <= 1'b0;
    end
    else
    begin
      cycle_start_o <= cycle_end;
      if (cycle_end)
      begin
        phase_cnt <= 3'h0;
        long_q <= long_cycle_i;
      end
      else if (phase_en_o)
        phase_cnt <= phase_cnt + 3'h1;
    end
  end

  assign write_clk_o = cycle_end;

  // =====================================================================
  // Port decode at the end of the instruction's last cycle
  logic instr_end;
  logic wr_commit;
  logic rd_commit;
  logic [3:0] port_wr;
  logic [4*WIDTH-1:0] port_latch;
  logic [4*WIDTH-1:0] port_rd;

  assign instr_end = cycle_end && last_cycle_i;
  assign wr_commit = instr_end && io_write_i;
  assign rd_commit = instr_end && io_read_i;
  assign port_wr[0] = wr_commit && (io_port_i == `MCT_PORT0);
  assign port_wr[1] = wr_commit && (io_port_i == `MCT_PORT1);
  assign port_wr[2] = wr_commit && (io_port_i == `MCT_PORT4);
  assign port_wr[3] = wr_commit && (io_port_i == `MCT_PORT5);

  // Four port bytes
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_port
      mct_port_line #(.WIDTH(WIDTH)) u_line
      (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .wr_i(port_wr[gi]),
        .data_i(io_wdata_i),
        .pin_i(port_pin_i[gi*WIDTH +: WIDTH]),
        .pin_o(port_pin_o[gi*WIDTH +: WIDTH]),
        .pin_oe_o(port_pin_oe_o[gi*WIDTH +: WIDTH]),
        .latch_o(port_latch[gi*WIDTH +: WIDTH]),
        .rd_o(port_rd[gi*WIDTH +: WIDTH])
      );
    end
  endgenerate

  // Read data select
  logic [WIDTH-1:0] next_rdata;

  assign next_rdata = (io_port_i == `MCT_PORT0) ? port_rd[0*WIDTH +: WIDTH] :
                      (io_port_i == `MCT_PORT1) ? port_rd[1*WIDTH +: WIDTH] :
                      (io_port_i == `MCT_PORT4) ? port_rd[2*WIDTH +: WIDTH] :
                      (io_port_i == `MCT_PORT5) ? port_rd[3*WIDTH +: WIDTH] : '0;

  // Timer and control-port strobes and read data
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      io_rdata_o <= '0;
      timer_write_o <= 1'b0;
      timer_wdata_o <= '0;
      timer_capture_o <= 1'b0;
      icp_write_o <= 1'b0;
    end
    else
    begin
      if (io_read_i)
        io_rdata_o <= next_rdata;
      timer_write_o <= wr_commit && (io_port_i == `MCT_PORT_TIMER);
      icp_write_o <= wr_commit && (io_port_i == `MCT_PORT_ICP);
      if (wr_commit)
        timer_wdata_o <= io_wdata_i;
      timer_capture_o <= rd_commit && (io_port_i == `MCT_PORT_TIMER);
    end
  end

  // =====================================================================
  // Ready pulse sequencer
  mct_stb_e stb_state;
  logic [SCW-1:0] stb_cnt;

  // Wait after the port write, then drive one low pulse; a new write restarts it
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      stb_state <= MCT_STB_IDLE;
      stb_cnt <= '0;
      ready_strobe_n_o <= 1'b1;
    end
    else if (port_wr[2])
    begin
      stb_state <= MCT_STB_WAIT;
      stb_cnt <= '0;
      ready_strobe_n_o <= 1'b1;
    end
    else
    begin
      unique case (stb_state)
        MCT_STB_IDLE:
          ready_strobe_n_o <= 1'b1;
        MCT_STB_WAIT:
        begin
          stb_cnt <= stb_cnt + SCW'(1);
          if (stb_cnt == STB_DELAY_LAST)
          begin
            stb_state <= MCT_STB_LOW;
            stb_cnt <= '0;
            ready_strobe_n_o <= 1'b0;
          end
        end
        MCT_STB_LOW:
        begin
          stb_cnt <= stb_cnt + SCW'(1);
          if (stb_cnt == STB_LOW_LAST)
          begin
            stb_state <= MCT_STB_IDLE;
            stb_cnt <= '0;
            ready_strobe_n_o <= 1'b1;
          end
        end
        default:
        begin
          stb_state <= MCT_STB_IDLE;
          ready_strobe_n_o <= 1'b1;
        end
      endcase
    end
  end

  // =====================================================================
  // Event input conditioning
  logic evt_active;
  logic irq_rise;
  logic tmr_level;
  logic tmr_rise;

  assign evt_active = event_active_high_i ? evt_sync : !evt_sync;

  // Interrupt path needs the longer hold
  mct_level_filter #(.STABLE(`MCT_EVT_IRQ_PH), .INIT(1'b0)) u_irq_filt
  (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .phase_en_i(phase_en_o),
    .level_i(evt_active),
    .level_o(),
    .rise_o(irq_rise),
    .fall_o()
  );

  // Timer path counts shorter pulses
  mct_level_filter #(.STABLE(`MCT_EVT_TMR_PH), .INIT(1'b0)) u_tmr_filt
  (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .phase_en_i(phase_en_o),
    .level_i(evt_active),
    .level_o(tmr_level),
    .rise_o(tmr_rise),
    .fall_o()
  );

  assign event_level_o = tmr_level;
  assign event_count_o = tmr_rise;

  // =====================================================================
  // Interrupt request latch and cycle-aligned request
  logic irq_latch;

  // Set wins over acknowledge; request shows from the next cycle start
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      irq_latch <= 1'b0;
      irq_request_o <= 1'b0;
    end
    else if (core_reset_o)
    begin
      irq_latch <= 1'b0;
      irq_request_o <= 1'b0;
    end
    else
    begin
      if (irq_rise)
        irq_latch <= 1'b1;
      else if (irq_ack_i)
        irq_latch <= 1'b0;
      if (irq_ack_i && !irq_rise)
        irq_request_o <= 1'b0;
      else if (cycle_end && (irq_latch || irq_rise))
        irq_request_o <= 1'b1;
    end
  end

  // Taken only at a non-privileged instruction boundary
  assign irq_take_o = irq_request_o && instr_end && !privileged_i;

  // =====================================================================
  // Prescaled tick, free running from the last timer write
  logic [WIDTH-1:0] pre_cnt;
  logic pre_last;

  assign pre_last = (pre_cnt + WIDTH'(1) >= prescale_i);

  // Reload on wrap only, so interval error never builds up
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pre_cnt <= '0;
      timer_tick_o <= 1'b0;
    end
    else if (timer_write_o)
    begin
      pre_cnt <= '0;
      timer_tick_o <= 1'b0;
    end
    else
    begin
      timer_tick_o <= phase_en_o && pre_last;
      if (phase_en_o)
        pre_cnt <= pre_last ? '0 : pre_cnt + WIDTH'(1);
    end
  end

endmodule : mct_machine_cycle_timing

`default_nettype wire

// file: src/mct_defs.svh
/*
  Timing, address and reset constants of the machine-cycle timing block.
  Assumes a 25 MHz time-base clock; it is included by its bare name.
*/
`ifndef MCT_DEFS_SVH
`define MCT_DEFS_SVH

// =====================================================================
// Clock rates
`define MCT_CLK_PERIOD_NS 40
`define MCT_TB_PER_PHASE 2
`define MCT_PHASE_NS (`MCT_CLK_PERIOD_NS * `MCT_TB_PER_PHASE)

// =====================================================================
// Machine cycle lengths, in phase clocks
`define MCT_SHORT_PHASES 4
`define MCT_LONG_PHASES 6

// =====================================================================
// Ready pulse, in phase clocks
`define MCT_STB_DELAY_PH 3
`define MCT_STB_LOW_MIN_PH 8
`define MCT_STB_LOW_MAX_PH 12
`define MCT_STB_LOW_PH 10

// =====================================================================
// Event input hold times, in phase clocks
`define MCT_EVT_IRQ_PH 6
`define MCT_EVT_TMR_PH 2

// =====================================================================
// Free-running interval tolerance, in phase clocks
`define MCT_INTERVAL_TOL_PH 6

// =====================================================================
// Port addresses and reset values
`define MCT_PORT_W 3
`define MCT_PORT0 3'h0
`define MCT_PORT1 3'h1
`define MCT_PORT4 3'h4
`define MCT_PORT5 3'h5
`define MCT_PORT_ICP 3'h6
`define MCT_PORT_TIMER 3'h7
`define MCT_LATCH_RESET 8'hFF
`define MCT_RESET_VECTOR 11'h000

`endif

// file: src/mct_pkg.sv
/*
  Types shared by the machine-cycle timing block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package mct_pkg;

  // =====================================================================
  // Ready pulse sequencer states
  typedef enum logic [1:0]
  {
    MCT_STB_IDLE = 2'b00,
    MCT_STB_WAIT = 2'b01,
    MCT_STB_LOW = 2'b10
  } mct_stb_e;

endpackage : mct_pkg

// file: src/mct_level_filter.sv
/*
  Level filter: the output follows the input only after the input has
  held a new level for STABLE consecutive phase enables.
  Assumes the input is already synchronised to clock_i.
*/
`timescale 1ns/1ns
`default_nettype none

module mct_level_filter
#(
  parameter int unsigned STABLE = 6,
  parameter logic INIT = 1'b0
)
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic phase_en_i,
  input wire logic level_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);

  localparam int unsigned CW = $clog2(STABLE + 1);
  localparam logic [CW-1:0] LAST = CW'(STABLE - 1);

  logic [CW-1:0] run;
  logic differs;
  logic flip;

  // =====================================================================
  // Stability decision
  assign differs = level_i != level_o;
  assign flip = phase_en_i && differs && (run == LAST);

  // Count consecutive phases at the new level
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      run <= '0;
      level_o <= INIT;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end
    else
    begin
      rise_o <= flip && !level_o;
      fall_o <= flip && level_o;
      if (!differs)
        run <= '0;
      else if (flip)
      begin
        run <= '0;
        level_o <= level_i;
      end
      else if (phase_en_i)
        run <= run + CW'(1);
    end
  end

endmodule : mct_level_filter

`default_nettype wire

// file: src/mct_port_line.sv
/*
  One bidirectional port byte: output latch plus synchronised pin read.
  A latch bit of one releases the line so it can serve as an input.
  Assumes pin levels arrive from outside the clock domain.
*/
`timescale 1ns/1ns
`default_nettype none

`include "mct_defs.svh"

module mct_port_line
#(
  parameter int unsigned WIDTH = 8
)
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic wr_i,
  input wire logic [WIDTH-1:0] data_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] pin_o,
  output logic [WIDTH-1:0] pin_oe_o,
  output logic [WIDTH-1:0] latch_o,
  output logic [WIDTH-1:0] rd_o
);

  logic [WIDTH-1:0] pin_meta;

  // =====================================================================
  // Output latch holds the last written value
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      latch_o <= WIDTH'(`MCT_LATCH_RESET);
    else if (wr_i)
      latch_o <= data_i;
  end

  // Pin synchroniser
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pin_meta <= '1;
      rd_o <= '1;
    end
    else
    begin
      pin_meta <= pin_i;
      rd_o <= pin_meta;
    end
  end

  // Drive low only where the latch holds zero
  assign pin_o = '0;
  assign pin_oe_o = ~latch_o;

endmodule : mct_port_line

`default_nettype wire

// file: test/mct_ready_peer.sv
/*
  Peripheral on the ready port: latches port 4 data at each strobe fall,
  times the low pulse, then offers new input data after the strobe ends.
  Assumes the bench resolves the port 4 wire and feeds it back here.
*/
`timescale 1ns/1ns
`default_nettype none

module mct_ready_peer
#(
  parameter int ACK_DLY = 3
)
(
  input wire logic clock_i,
  input wire logic strobe_n_i,
  input wire logic [7:0] wire_i,
  output var logic [7:0] ext_o
);
  logic [7:0] got[$];
  int low_len;
  int wait_cnt;
  logic prev = 1'b1;
  initial ext_o = 8'hC3;
  // ======
  // Capture data, count low clocks, change input data after the ack
  always @(posedge clock_i)
  begin
    if (prev && !strobe_n_i)
    begin
      got.push_back(wire_i);
      low_len = 0;
    end
    if (!strobe_n_i)
      low_len++;
    if (!prev && strobe_n_i)
      wait_cnt = ACK_DLY;
    else if (wait_cnt > 0)
    begin
      wait_cnt--;
      if (wait_cnt == 0)
        ext_o <= ext_o + 8'h35;
    end
    prev = strobe_n_i;
  end
endmodule : mct_ready_peer

`default_nettype wire

// file: test/mct_timing_monitor.sv
/*
  Port checker of the machine-cycle timing block, bound to its top.
  Assumes one clock domain with asynchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none

module mct_timing_monitor
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic reset_pin_n_i,
  input wire logic long_cycle_i,
  input wire logic last_cycle_i,
  input wire logic io_write_i,
  input wire logic io_read_i,
  input wire logic [2:0] io_port_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic [31:0] port_pin_oe_o,
  input wire logic phase_en_o,
  input wire logic write_clk_o,
  input wire logic ready_strobe_n_o,
  input wire logic core_reset_o,
  input wire logic timer_write_o,
  input wire logic [7:0] timer_wdata_o,
  input wire logic timer_capture_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  // ======
  // Commit point and ready pulse shape
  sequence commit_s;
    write_clk_o && last_cycle_i;
  endsequence
  sequence low_run_s;
    !ready_strobe_n_o [*8] ##1 !ready_strobe_n_o [*8] ##1 !ready_strobe_n_o [*4] ##1 ready_strobe_n_o;
  endsequence
  // ======
  // Assertions
  phase_alt_a: assert property (phase_en_o |=> !phase_en_o ##1 phase_en_o)
    else $error("phase enable out of step");
  short_cycle_a: assert property (disable iff (sys_rst_i || core_reset_o)
    write_clk_o && !long_cycle_i |=> !write_clk_o [*7] ##1 write_clk_o)
    else $error("short cycle length wrong");
  long_cycle_a: assert property (disable iff (sys_rst_i || core_reset_o)
    write_clk_o && long_cycle_i |=> !write_clk_o [*8] ##1 !write_clk_o [*3] ##1 write_clk_o)
    else $error("long cycle length wrong");
  ready_pulse_a: assert property (commit_s ##0 io_write_i && io_port_i == 3'h4 |-> ##7 low_run_s)
    else $error("ready pulse timing wrong");
  timer_load_a: assert property (commit_s ##0 io_write_i && io_port_i == 3'h7 |=>
    timer_write_o && timer_wdata_o == $past(io_wdata_i))
    else $error("timer load strobe wrong");
  timer_read_a: assert property (commit_s ##0 io_read_i && io_port_i == 3'h7 |=> timer_capture_o)
    else $error("timer capture missing");
  port_latch_a: assert property (commit_s ##0 io_write_i && io_port_i == 3'h0 |=>
    port_pin_oe_o[7:0] == ~$past(io_wdata_i))
    else $error("port latch not updated");
  reset_pin_a: assert property ($fell(reset_pin_n_i) |-> ##[1:6] core_reset_o)
    else $error("reset pin not taken");
endmodule : mct_timing_monitor

bind mct_machine_cycle_timing mct_timing_monitor u_mct_timing_monitor
(
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .reset_pin_n_i(reset_pin_n_i), .long_cycle_i(long_cycle_i),
  .last_cycle_i(last_cycle_i), .io_write_i(io_write_i), .io_read_i(io_read_i), .io_port_i(io_port_i),
  .io_wdata_i(io_wdata_i), .port_pin_oe_o(port_pin_oe_o), .phase_en_o(phase_en_o),
  .write_clk_o(write_clk_o), .ready_strobe_n_o(ready_strobe_n_o), .core_reset_o(core_reset_o),
  .timer_write_o(timer_write_o), .timer_wdata_o(timer_wdata_o), .timer_capture_o(timer_capture_o)
);

`default_nettype wire

// file: test/tb.sv
/*
  Self-checking bench: drives decoder, pins and event input, compares
  with queue models. Assumes the design files and the ready-port peer.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mct_defs.svh"

module tb;
  logic clk, rst, rpin_n, evt, evt_hi, lng, last, priv, wr, rd, ack;
  logic [2:0] port;
  logic [7:0] wd, psc, rdata, tdata, ext4, d, v4;
  logic [31:0] pin_in, pin_out, pin_oe, ext;
  logic ph_en, wclk, cstart, stb_n, core_rst, t_wr, t_cap, icp_wr, lvl, ecnt, irq, take, tick;
  logic [10:0] vec;
  int error_cnt, samples_checked, cyc, ph, n_evt, n_take, n, ps;
  int wq[$], pq[$], tq[$];
  logic lq[$];
  int pt[5] = '{0, 1, 4, 5, 4};
  // Released lines follow the pull-ups or the peer
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & {ext[31:24], ext4, ext[15:0]});
  mct_machine_cycle_timing u_mct_machine_cycle_timing
  (
    .clock_i(clk), .sys_rst_i(rst), .reset_pin_n_i(rpin_n), .external_event_input_i(evt),
    .event_active_high_i(evt_hi), .long_cycle_i(lng), .last_cycle_i(last), .privileged_i(priv),
    .io_write_i(wr), .io_read_i(rd), .io_port_i(port), .io_wdata_i(wd), .prescale_i(psc),
    .irq_ack_i(ack), .port_pin_i(pin_in), .port_pin_o(pin_out), .port_pin_oe_o(pin_oe),
    .io_rdata_o(rdata), .phase_en_o(ph_en), .write_clk_o(wclk), .cycle_start_o(cstart),
    .ready_strobe_n_o(stb_n), .core_reset_o(core_rst), .reset_vector_o(vec), .timer_write_o(t_wr),
    .timer_wdata_o(tdata), .timer_capture_o(t_cap), .icp_write_o(icp_wr), .event_level_o(lvl),
    .event_count_o(ecnt), .irq_request_o(irq), .irq_take_o(take), .timer_tick_o(tick)
  );
  mct_ready_peer u_mct_ready_peer
  (
    .clock_i(clk), .strobe_n_i(stb_n), .wire_i(pin_in[23:16]), .ext_o(ext4)
  );
  // ======
  // Clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end
  // Cycle, phase, event, take and tick log
  always @(posedge clk)
  begin
    cyc++;
    if (ph_en) ph++;
    if (wclk)
    begin
      wq.push_back(cyc);
      pq.push_back(ph);
      lq.push_back(lng);
      ph = 0;
    end
    if (ecnt) n_evt++;
    if (take) n_take++;
    if (tick) tq.push_back(cyc);
  end
  // ======
  // Helpers
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  task automatic end_of_test();
    if (error_cnt == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  // One port instruction held until it commits at a last-cycle end
  task automatic instr(input logic w, input logic [2:0] p, input logic [7:0] v);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    port <= p;
    wd <= v;
    last <= 1'b1;
    @(negedge clk);
    for (n = 0; n < 20 && wclk !== 1'b1; n++) @(negedge clk);
    chk("write clock", wclk, 1'b1);
    @(posedge clk);
    {wr, rd, last} <= 3'b000;
  endtask : instr
  // ======
  // Scenarios
  initial
  begin
    rst = 1'b1;
    rpin_n = 1'b1;
    {evt, lng, last, priv, wr, rd, ack} = 7'h00;
    evt_hi = 1'b1;
    port = 3'h0;
    wd = 8'h00;
    psc = 8'h01;
    ext = 32'hFFFFFFFF;
    void'($urandom(6817));
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("strobe in reset", stb_n, 1'b1);
    chk("core reset", core_rst, 1'b1);
    chk("port enables", pin_oe, 32'h00000000);
    @(posedge clk);
    rst <= 1'b0;
    for (n = 0; n < 20 && core_rst !== 1'b0; n++) @(negedge clk);
    chk("start address", vec, `MCT_RESET_VECTOR);
    // Random short and long machine cycles
    wq.delete();
    pq.delete();
    lq.delete();
    for (int k = 0; k < 12; k++)
    begin
      @(negedge clk);
      while (wclk !== 1'b1) @(negedge clk);
      @(posedge clk);
      lng <= (k == 1) ? 1'b1 : 1'($urandom);
      @(negedge clk);
      chk("cycle start", cstart, 1'b1);
    end
    for (int i = 1; i < wq.size(); i++)
    begin
      chk("cycle clocks", wq[i] - wq[i - 1], lq[i - 1] ? 12 : 8);
      chk("cycle phases", pq[i], lq[i - 1] ? 6 : 4);
    end
    @(posedge clk);
    lng <= 1'b0;
    ext <= $urandom;
    // Port latches, pin reads and ready strobe, last one a dummy zero
    for (int k = 0; k < 5; k++)
    begin
      d = (k == 4) ? 8'h00 : 8'($urandom);
      v4 = ext4;
      instr(1'b1, 3'(pt[k]), d);
      @(negedge clk);
      for (n = 1; n < 30 && pt[k] == 4 && stb_n !== 1'b0; n++) @(negedge clk);
      if (pt[k] == 4)
        chk("strobe delay", n, 2 * `MCT_STB_DELAY_PH + 1);
      repeat (40) @(posedge clk);
      if (pt[k] == 4)
      begin
        chk("strobe width", u_mct_ready_peer.low_len, 2 * `MCT_STB_LOW_PH);
        chk("peer data", u_mct_ready_peer.got.pop_front(), d & v4);
      end
      instr(1'b0, 3'(pt[k]), 8'h00);
      @(negedge clk);
      chk("port read", rdata, d & (k >= 2 ? (pt[k] == 4 ? ext4 : ext[31:24]) : ext[k * 8 +: 8]));
    end
    // Timer load, tick spacing and capture
    for (int s = 0; s < 3; s++)
    begin
      ps = $urandom % 8;
      @(posedge clk);
      psc <= 8'(ps);
      d = 8'($urandom);
      instr(1'b1, 3'h7, d);
      @(negedge clk);
      chk("timer load", t_wr, 1'b1);
      chk("timer data", tdata, d);
      tq.delete();
      repeat (100) @(posedge clk);
      for (int i = 2; i < tq.size(); i++)
        chk("tick spacing", tq[i] - tq[i - 1], 2 * (ps == 0 ? 1 : ps));
      chk("tick count", tq.size() > 4, 1'b1);
      instr(1'b0, 3'h7, 8'h00);
      @(negedge clk);
      chk("timer capture", t_cap, 1'b1);
    end
    // Control port write strobes only its own line
    instr(1'b1, 3'h6, 8'h5A);
    @(negedge clk);
    chk("control port strobe", icp_wr, 1'b1);
    chk("timer left alone", t_wr, 1'b0);
    // Event input in both polarities: short pulse counts, long one interrupts
    for (int pol = 0; pol < 2; pol++)
    begin
      @(posedge clk);
      evt_hi <= 1'(pol);
      evt <= !pol;
      repeat (30) @(posedge clk);
      n_evt = 0;
      evt <= 1'(pol);
      repeat (6) @(posedge clk);
      evt <= !pol;
      repeat (30) @(posedge clk);
      chk("event count", n_evt, 1);
      chk("short pulse request", irq, 1'b0);
      chk("event idle level", lvl, 1'b0);
      n_take = 0;
      evt <= 1'(pol);
      repeat (40) @(posedge clk);
      chk("request", irq, 1'b1);
      chk("event level", lvl, 1'b1);
      priv <= 1'b1;
      last <= 1'b1;
      repeat (16) @(posedge clk);
      chk("take when privileged", n_take, 0);
      priv <= 1'b0;
      repeat (16) @(posedge clk);
      chk("take", n_take > 0, 1'b1);
      last <= 1'b0;
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      evt <= !pol;
      repeat (3) @(posedge clk);
      chk("request cleared", irq, 1'b0);
    end
    // Reset pin held seven phases mid-run
    @(posedge clk);
    rpin_n <= 1'b0;
    repeat (14) @(posedge clk);
    chk("core held", core_rst, 1'b1);
    rpin_n <= 1'b1;
    for (n = 0; n < 20 && core_rst !== 1'b0; n++) @(negedge clk);
    chk("core released", core_rst, 1'b0);
    chk("restart address", vec, `MCT_RESET_VECTOR);
    end_of_test();
  end
endmodule : tb

`default_nettype wire
